// File: core/usc_consts.svh
// Offsets, field positions, codes and reset values of the serial control block
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH

// ==========================================
// Register byte offsets
`define USC_OFS_CTRL    5'h00
`define USC_OFS_ENABLE  5'h04
`define USC_OFS_TXDATA  5'h08
`define USC_OFS_RXDATA  5'h0C
`define USC_OFS_STATUS  5'h10

// ==========================================
// Control field positions
`define USC_CTRL_DIR    0
`define USC_CTRL_BRK    1
`define USC_CTRL_MARK   2
`define USC_CTRL_PAR_LO 3
`define USC_CTRL_PAR_HI 4
`define USC_CTRL_AM_LO  5
`define USC_CTRL_AM_HI  7

// ==========================================
// Parity codes
`define USC_PAR_NONE    2'h0
`define USC_PAR_EVEN    2'h1
`define USC_PAR_ODD     2'h2
`define USC_PAR_MS      2'h3

// ==========================================
// Receive addressing codes
`define USC_AM_NONE     3'h0
`define USC_AM_SW_BYTE  3'h1
`define USC_AM_SW_DET   3'h2
`define USC_AM_HW_BYTE  3'h3
`define USC_AM_HW_DET   3'h4

// ==========================================
// Status bit positions
`define USC_ST_TXBUSY   0
`define USC_ST_RXFULL   1
`define USC_ST_PERR     2
`define USC_ST_FERR     3
`define USC_ST_OVR      4
`define USC_ST_MARK     5
`define USC_ST_AHIT     6

// ==========================================
// Reset values and small constants
`define USC_CTRL_RST    8'h00
`define USC_LAST_BIT    3'h7
`define USC_CNT_W       16

`endif

// File: core/usc_pkg.sv
// Types shared by the serial control block
`default_nettype none
package usc_pkg;
    // Transmit sequencer, one-hot
    typedef enum logic [4:0] {
        USC_TX_IDLE  = 5'h01,
        USC_TX_START = 5'h02,
        USC_TX_DATA  = 5'h04,
        USC_TX_PAR   = 5'h08,
        USC_TX_STOP  = 5'h10
    } usc_tx_e;
    // Receive sequencer, one-hot
    typedef enum logic [4:0] {
        USC_RX_IDLE  = 5'h01,
        USC_RX_START = 5'h02,
        USC_RX_DATA  = 5'h04,
        USC_RX_PAR   = 5'h08,
        USC_RX_STOP  = 5'h10
    } usc_rx_e;
endpackage
`default_nettype wire

// File: core/usc_core.sv
// Serial transceiver with its control register behind an AHB-Lite slave
// Operation
// - Half duplex: direction 0 receives, 1 transmits
// - Break request bit drives break on line
// - Mark/space parity sends the mark bit
// - Two-bit parity field governs next transmit frame; receive follows it live
// - Parity options: none, even, odd, mark/space
// - Three-bit receive addressing field
// - Five addressing options, including none
// - Eight-bit control register, full-width writes
// - Control read returns held value
// - Disabled block stops transmitter and receiver
//
// Implementation choices: the address map and register access over AHB-Lite.
`include "usc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module usc_core #(
    parameter logic [15:0] CLKS_PER_BIT = 16'h0364,
    parameter logic [7:0]  RX_ADDR      = 8'h01,
    parameter bit          HALF_DUPLEX  = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial line
    input  wire logic        line_rx,
    output logic             line_tx,
    output logic             line_tx_oe,
    // Addressing mode for the receive path
    output logic      [2:0]  rx_addressing_field
);
    import usc_pkg::*;

    // ==========================================
    // Constants
    localparam logic [15:0] LAST_CNT = CLKS_PER_BIT - 16'h0001;
    localparam logic [15:0] HALF_CNT = {1'b0, CLKS_PER_BIT[15:1]};

    // ==========================================
    // State
    typedef struct packed {
        logic [7:0]            ctrl;     // Control register
        logic                  en;       // Block enable
        logic                  wr_pend;  // Write data phase pending
        logic [4:0]            wr_addr;  // Latched write offset
        logic [31:0]           hrdata;   // Read data for the data phase
        usc_tx_e               tx_st;    // Transmit sequencer
        logic [7:0]            tx_sh;    // Transmit shifter
        logic [2:0]            tx_bit;   // Transmit bit index
        logic                  tx_par;   // Parity bit to send
        logic                  tx_np;    // Frame carries no parity
        logic [`USC_CNT_W-1:0] tx_cnt;   // Bit timer
        logic                  tx_pin;   // Registered line level
        usc_rx_e               rx_st;    // Receive sequencer
        logic [7:0]            rx_sh;    // Receive shifter
        logic [2:0]            rx_bit;   // Receive bit index
        logic                  rx_pb;    // Received parity bit
        logic [`USC_CNT_W-1:0] rx_cnt;   // Bit timer
        logic [7:0]            rx_data;  // Received byte
        logic                  rx_full;  // Byte waiting
        logic                  perr;     // Parity error, sticky
        logic                  ferr;     // Stop error, sticky
        logic                  ovr;      // Overrun, sticky
        logic                  mark;     // Last parity-position value
        logic                  ahit;     // Address matched
    } usc_state_s;

    usc_state_s s;       // Current state
    usc_state_s next_s;  // Next state

    // ==========================================
    // Decode helpers
    // Receive modes that detect addresses in hardware
    function automatic logic is_hw_mode(input logic [2:0] am);
        is_hw_mode = (am == `USC_AM_HW_BYTE) || (am == `USC_AM_HW_DET);
    endfunction

    // Parity bit for a byte under a parity code
    function automatic logic par_of(input logic [7:0] d, input logic [1:0] pt,
                                    input logic mk);
        case (pt)
            `USC_PAR_EVEN: par_of = ^d;
            `USC_PAR_ODD:  par_of = ~^d;
            default:       par_of = mk;
        endcase
    endfunction

    // ==========================================
    // Control decode
    logic [1:0] par_type;  // Current parity code
    logic       tx_ok;     // Transmitter may run
    logic       rx_ok;     // Receiver may run
    logic       acc;       // Address phase taken
    logic       tx_tick;   // Transmit bit boundary
    logic       rx_tick;   // Receive sample point
    logic       rx_half;   // Middle of start bit
    logic       keep;      // Received byte goes to the holder
    logic       is_addr;   // Received byte is an address

    assign par_type = s.ctrl[`USC_CTRL_PAR_HI:`USC_CTRL_PAR_LO];
    // Half duplex shares one transceiver, so direction picks one side
    assign tx_ok = s.en && (!HALF_DUPLEX || s.ctrl[`USC_CTRL_DIR]);
    assign rx_ok = s.en && (!HALF_DUPLEX || !s.ctrl[`USC_CTRL_DIR]);
    assign acc = hsel && htrans[1] && hready;
    assign tx_tick = (s.tx_cnt == LAST_CNT);
    assign rx_tick = (s.rx_cnt == LAST_CNT);
    assign rx_half = (s.rx_cnt == HALF_CNT);

    // ==========================================
    // Next-state logic
    always_comb begin
        next_s = s;
        keep = 1'b0;
        is_addr = 1'b0;

        // Data phase of a write lands here
        if (s.wr_pend) begin
            case (s.wr_addr)
                `USC_OFS_CTRL: begin
                    // Whole byte replaced; software merges fields itself
                    next_s.ctrl = hwdata[7:0];
                end
                `USC_OFS_ENABLE: begin
                    next_s.en = hwdata[0];
                end
                `USC_OFS_TXDATA: begin
                    // Ignored while a frame is running or sending is off
                    if (tx_ok && (s.tx_st == USC_TX_IDLE)) begin
                        next_s.tx_st = USC_TX_START;
                        next_s.tx_sh = hwdata[7:0];
                        next_s.tx_cnt = '0;
                        next_s.tx_np = (par_type == `USC_PAR_NONE);
                        next_s.tx_par = par_of(hwdata[7:0], par_type,
                                               s.ctrl[`USC_CTRL_MARK]);
                    end
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        next_s.wr_pend = acc && hwrite;
        next_s.wr_addr = haddr[4:0];

        // Read data is taken after any write of this cycle, so a read
        // right behind a write sees the new value
        if (acc && !hwrite) begin
            case (haddr[4:0])
                `USC_OFS_CTRL:   next_s.hrdata = {24'h000000, next_s.ctrl};
                `USC_OFS_ENABLE: next_s.hrdata = {31'h00000000, next_s.en};
                `USC_OFS_RXDATA: begin
                    next_s.hrdata = {24'h000000, s.rx_data};
                    next_s.rx_full = 1'b0;
                end
                `USC_OFS_STATUS: begin
                    next_s.hrdata = '0;
                    next_s.hrdata[`USC_ST_TXBUSY] = (s.tx_st != USC_TX_IDLE);
                    next_s.hrdata[`USC_ST_RXFULL] = s.rx_full;
                    next_s.hrdata[`USC_ST_PERR] = s.perr;
                    next_s.hrdata[`USC_ST_FERR] = s.ferr;
                    next_s.hrdata[`USC_ST_OVR] = s.ovr;
                    next_s.hrdata[`USC_ST_MARK] = s.mark;
                    next_s.hrdata[`USC_ST_AHIT] = s.ahit;
                    // Error flags clear on read; a new event below wins
                    next_s.perr = 1'b0;
                    next_s.ferr = 1'b0;
                    next_s.ovr = 1'b0;
                end
                default: next_s.hrdata = '0;
            endcase
        end

        // Transmit sequencer
        // Count only inside a running frame, so a fresh load keeps its zero
        // and the start bit lasts a whole bit time
        if (s.tx_st != USC_TX_IDLE) begin
            next_s.tx_cnt = tx_tick ? '0 : s.tx_cnt + 16'h0001;
        end
        case (s.tx_st)
            USC_TX_IDLE: begin
                next_s.tx_pin = 1'b1;
            end
            USC_TX_START: begin
                next_s.tx_pin = 1'b0;
                if (tx_tick) begin
                    next_s.tx_st = USC_TX_DATA;
                    next_s.tx_bit = '0;
                end
            end
            USC_TX_DATA: begin
                next_s.tx_pin = s.tx_sh[0];
                if (tx_tick) begin
                    next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
                    next_s.tx_bit = s.tx_bit + 3'h1;
                    if (s.tx_bit == `USC_LAST_BIT) begin
                        next_s.tx_st = s.tx_np ? USC_TX_STOP : USC_TX_PAR;
                    end
                end
            end
            USC_TX_PAR: begin
                next_s.tx_pin = s.tx_par;
                if (tx_tick) begin
                    next_s.tx_st = USC_TX_STOP;
                end
            end
            USC_TX_STOP: begin
                next_s.tx_pin = 1'b1;
                if (tx_tick) begin
                    next_s.tx_st = USC_TX_IDLE;
                end
            end
            default: begin
                next_s.tx_st = USC_TX_IDLE;
                next_s.tx_pin = 1'b1;
            end
        endcase
        // Disabled, or turned to receive in half duplex: frame aborted, line idles high
        if (!tx_ok) begin
            next_s.tx_st = USC_TX_IDLE;
            next_s.tx_pin = 1'b1;
        end
        // Break overrides any frame; releasing the bit hands the line back to the sequencer, high when idle
        // Allowance comes from the next values, so break starts on the same
        // edge as an enable or direction write
        if (next_s.en && (!HALF_DUPLEX || next_s.ctrl[`USC_CTRL_DIR]) &&
            next_s.ctrl[`USC_CTRL_BRK]) begin
            next_s.tx_pin = 1'b0;
        end

        // Receive sequencer
        if (s.rx_st != USC_RX_IDLE) begin
            next_s.rx_cnt = rx_tick ? '0 : s.rx_cnt + 16'h0001;
        end
        case (s.rx_st)
            USC_RX_IDLE: begin
                if (!line_rx) begin
                    next_s.rx_st = USC_RX_START;
                    next_s.rx_cnt = '0;
                end
            end
            USC_RX_START: begin
                // Re-check mid-bit so a glitch does not start a frame
                if (rx_half) begin
                    next_s.rx_cnt = '0;
                    next_s.rx_bit = '0;
                    next_s.rx_st = line_rx ? USC_RX_IDLE : USC_RX_DATA;
                end
            end
            USC_RX_DATA: begin
                if (rx_tick) begin
                    next_s.rx_sh = {line_rx, s.rx_sh[7:1]};
                    next_s.rx_bit = s.rx_bit + 3'h1;
                    if (s.rx_bit == `USC_LAST_BIT) begin
                        next_s.rx_st = (par_type == `USC_PAR_NONE) ?
                                       USC_RX_STOP : USC_RX_PAR;
                    end
                end
            end
            USC_RX_PAR: begin
                if (rx_tick) begin
                    next_s.rx_pb = line_rx;
                    next_s.rx_st = USC_RX_STOP;
                end
            end
            USC_RX_STOP: begin
                if (rx_tick) begin
                    next_s.rx_st = USC_RX_IDLE;
                    if (!line_rx) begin
                        next_s.ferr = 1'b1;
                    end
                    if (par_type == `USC_PAR_MS) begin
                        next_s.mark = s.rx_pb;
                    end else if ((par_type != `USC_PAR_NONE) &&
                                 (s.rx_pb != par_of(s.rx_sh, par_type, 1'b0))) begin
                        next_s.perr = 1'b1;
                    end
                    // Mark in the parity slot tags an address byte
                    is_addr = is_hw_mode(rx_addressing_field) &&
                              (par_type == `USC_PAR_MS) && s.rx_pb;
                    if (is_addr) begin
                        next_s.ahit = (s.rx_sh == RX_ADDR);
                        // Per-byte mode hands the matching address up too
                        keep = (s.rx_sh == RX_ADDR) &&
                               (rx_addressing_field == `USC_AM_HW_BYTE);
                    end else begin
                        // Hardware modes pass data only after a match
                        keep = !is_hw_mode(rx_addressing_field) || s.ahit;
                    end
                    if (keep) begin
                        if (next_s.rx_full) begin
                            next_s.ovr = 1'b1;
                        end else begin
                            next_s.rx_data = s.rx_sh;
                            next_s.rx_full = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_s.rx_st = USC_RX_IDLE;
            end
        endcase
        // Receiver parked while disabled or transmitting in half duplex
        if (!rx_ok) begin
            next_s.rx_st = USC_RX_IDLE;
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '0;
            s.ctrl <= `USC_CTRL_RST;
            s.tx_st <= USC_TX_IDLE;
            s.rx_st <= USC_RX_IDLE;
            s.tx_pin <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // Outputs
    assign hrdata = s.hrdata;
    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign line_tx = s.tx_pin;
    // Transceiver driven only while sending in half duplex
    assign line_tx_oe = !HALF_DUPLEX || (s.en && s.ctrl[`USC_CTRL_DIR]);
    assign rx_addressing_field = s.ctrl[`USC_CTRL_AM_HI:`USC_CTRL_AM_LO];

endmodule
`default_nettype wire

// File: test/usc_core_assertions.sv
// Port-level checker for the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.svh"
module usc_core_checker #(
    parameter logic [15:0] CLKS_PER_BIT = 16'h0364,
    parameter bit          HALF_DUPLEX  = 1'b0
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Serial side
    input wire logic        line_tx,
    input wire logic        line_tx_oe,
    input wire logic [2:0]  rx_addressing_field
);
    // ==========================================
    // Shadow registers rebuilt from bus traffic and the transmit line
    logic        dp_wr;   // Write data phase in progress
    logic        dp_rd;   // Read data phase in progress
    logic [4:0]  dp_ofs;  // Offset of that data phase
    logic [7:0]  ctrl_q;  // Expected control value
    logic        en_q;    // Expected enable
    logic [15:0] low_cnt; // Length of the current low run
    logic        taint;   // Run touched by break or abort, so not bit aligned
    logic        tx_ok;   // Transmitter allowed
    assign tx_ok = en_q && (!HALF_DUPLEX || ctrl_q[`USC_CTRL_DIR]);
    // Shadow update on the same edge the block loads its registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_ofs  <= 5'h00;
            ctrl_q  <= 8'h00;
            en_q    <= 1'b0;
            low_cnt <= 16'h0000;
            taint   <= 1'b0;
        end else begin
            dp_wr   <= hsel && htrans[1] && hready && hwrite;
            dp_rd   <= hsel && htrans[1] && hready && !hwrite;
            dp_ofs  <= haddr[4:0];
            if (dp_wr && dp_ofs == `USC_OFS_CTRL) ctrl_q <= hwdata[7:0];
            if (dp_wr && dp_ofs == `USC_OFS_ENABLE) en_q <= hwdata[0];
            low_cnt <= line_tx ? 16'h0000 : low_cnt + 16'h0001;
            taint   <= !line_tx && (taint || ctrl_q[`USC_CTRL_BRK] || !tx_ok);
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reset_out: assert property ($fell(srst) |-> line_tx && hrdata == 32'h0 &&
        rx_addressing_field == 3'h0) else $error("bad output after reset");
    a_ctrl_read: assert property (dp_rd && dp_ofs == `USC_OFS_CTRL |->
        hrdata == {24'h0, ctrl_q}) else $error("control read mismatch");
    a_en_read: assert property (dp_rd && dp_ofs == `USC_OFS_ENABLE |->
        hrdata == {31'h0, en_q}) else $error("enable read mismatch");
    a_gap_read: assert property (dp_rd && dp_ofs > `USC_OFS_STATUS |->
        hrdata == 32'h0) else $error("unmapped read not zero");
    a_field_track: assert property (rx_addressing_field == ctrl_q[7:5])
        else $error("addressing field does not follow control");
    a_oe_level: assert property (line_tx_oe == (HALF_DUPLEX ? tx_ok : 1'b1))
        else $error("drive enable wrong for direction");
    a_break_low: assert property (tx_ok && ctrl_q[`USC_CTRL_BRK] |-> !line_tx)
        else $error("line not low during break");
    a_dis_idle: assert property (!en_q && !$past(en_q) |-> line_tx)
        else $error("line not idle while disabled");
    a_bit_width: assert property (line_tx && low_cnt != 16'h0 && !taint && tx_ok
        |-> low_cnt % CLKS_PER_BIT == 16'h0) else $error("low run not whole bits");
endmodule
bind usc_core usc_core_checker #(
    .CLKS_PER_BIT(CLKS_PER_BIT),
    .HALF_DUPLEX (HALF_DUPLEX)
) u_chk (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_tx(line_tx),
    .line_tx_oe(line_tx_oe), .rx_addressing_field(rx_addressing_field)
);
`default_nettype wire

// File: test/usc_serial_node.sv
// Remote serial node: sends frames to the block and captures its frames
`timescale 1ns/1ps
`default_nettype none
module usc_serial_node #(
    parameter int CLKS = 8
) (
    // Clock
    input wire logic ref_clk,
    // Line
    input wire logic line_tx,
    output var logic line_rx
);
    // Idle line rests high, like a pulled-up wire
    initial line_rx = 1'b1;
    // Send start, eight data bits LSB first, optional parity, stop
    task automatic send_frame(input logic [7:0] d, input bit has_par, input logic p);
        int i;
        @(posedge ref_clk);
        line_rx <= 1'b0;
        repeat (CLKS) @(posedge ref_clk);
        for (i = 0; i < 8; i++) begin
            line_rx <= d[i];
            repeat (CLKS) @(posedge ref_clk);
        end
        if (has_par) begin
            line_rx <= p;
            repeat (CLKS) @(posedge ref_clk);
        end
        line_rx <= 1'b1;
        repeat (CLKS) @(posedge ref_clk);
    endtask
    // Capture one frame, sampling mid-bit; bounded wait for the start edge
    task automatic get_frame(input bit has_par, output logic [7:0] d,
                             output logic p, output logic s);
        int i;
        d = 8'h00;
        p = 1'b1;
        for (i = 0; i < 300 && line_tx !== 1'b0; i++) @(posedge ref_clk);
        repeat (CLKS / 2) @(posedge ref_clk);
        for (i = 0; i < 8; i++) begin
            repeat (CLKS) @(posedge ref_clk);
            d[i] = line_tx;
        end
        if (has_par) begin
            repeat (CLKS) @(posedge ref_clk);
            p = line_tx;
        end
        repeat (CLKS) @(posedge ref_clk);
        s = line_tx;
    endtask
endmodule
`default_nettype wire

// File: test/uart_control_register_tb_top.sv
// Self-checking bench for the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.svh"
module uart_control_register_tb_top;
    // ==========================================
    // Signals
    logic        ref_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
    logic        line_rx, line_tx, line_tx_oe;
    logic [1:0]  htrans;
    logic [2:0]  hsize, rx_addressing_field;
    logic [31:0] haddr, hwdata, hrdata;
    int          bad_count = 0;
    int          compares = 0;
    assign hready = hreadyout; // Single slave owns the bus ready
    usc_core #(.CLKS_PER_BIT(16'h0008), .HALF_DUPLEX(1'b1)) dut (
        .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_rx(line_rx),
        .line_tx(line_tx), .line_tx_oe(line_tx_oe),
        .rx_addressing_field(rx_addressing_field));
    usc_serial_node #(.CLKS(8)) node (.ref_clk(ref_clk), .line_tx(line_tx),
        .line_rx(line_rx));
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single transfer; waits on ready, never assumes latency
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {27'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
    endtask
    // Poll a status bit, bounded
    task automatic wait_st(input int b, input logic v);
        logic [31:0] q;
        for (int i = 0; i < 200; i++) begin
            bus(1'b0, `USC_OFS_STATUS, 32'h0, q);
            if (q[b] === v) return;
        end
        bad_count++;
        $display("Error at %0t: status wait timed out", $time);
    endtask
    task automatic wrap_up();
        $display("Compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    // Control reset value, unmapped place, upper control bits dropped
    task automatic t_regs();
        logic [31:0] q;
        bus(1'b0, `USC_OFS_CTRL, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, 5'h14, 32'hFFFF_FFFF, q);
        bus(1'b0, 5'h14, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, `USC_OFS_CTRL, 32'hFFFF_FF00, q);
        bus(1'b0, `USC_OFS_CTRL, 32'h0, q);
        chk(q, 32'h0);
    endtask
    // Every parity and addressing code by read-modify-write
    task automatic t_fields();
        logic [31:0] q, v;
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 5; m++) begin
                bus(1'b0, `USC_OFS_CTRL, 32'h0, q);
                v = {24'h0, m[2:0], p[1:0], q[2:0]};
                bus(1'b1, `USC_OFS_CTRL, v, q);
                bus(1'b0, `USC_OFS_CTRL, 32'h0, q);
                chk(q, v);
                chk(rx_addressing_field, m[2:0]);
            end
        end
        bus(1'b1, `USC_OFS_CTRL, 32'h0000_00FF, q);
        bus(1'b0, `USC_OFS_CTRL, 32'h0, q);
        chk(q, 32'h0000_00FF);
    endtask
    // Frames under each parity selection, both mark values
    task automatic t_tx();
        logic [31:0] q;
        logic [7:0]  d;
        logic [1:0]  par;
        logic        p, s, mk, e;
        bus(1'b1, `USC_OFS_ENABLE, 32'h1, q);
        for (int k = 0; k < 5; k++) begin
            par = (k < 4) ? k[1:0] : 2'h3;
            mk = (k != 4);
            bus(1'b1, `USC_OFS_CTRL, {27'h0, par, mk, 2'b01}, q);
            @(posedge ref_clk);
            chk(line_tx_oe, 1'b1);
            wait_st(`USC_ST_TXBUSY, 1'b0);
            bus(1'b1, `USC_OFS_TXDATA, 32'h0000_00A6, q);
            node.get_frame(par != 2'h0, d, p, s);
            e = (par == 2'h1) ? ^8'hA6 : (par == 2'h2) ? ~^8'hA6 : (par == 2'h3) ? mk : 1'b1;
            chk(d, 8'hA6);
            chk(p, e);
            chk(s, 1'b1);
        end
    endtask
    // Break holds the line low until cleared
    task automatic t_break();
        logic [31:0] q;
        bus(1'b1, `USC_OFS_CTRL, 32'h0000_0003, q);
        repeat (40) @(posedge ref_clk);
        chk(line_tx, 1'b0);
        bus(1'b1, `USC_OFS_CTRL, 32'h0000_0001, q);
        repeat (120) @(posedge ref_clk);
        chk(line_tx, 1'b1);
    endtask
    // Receive direction: drive off, byte arrives
    task automatic t_rx();
        logic [31:0] q;
        bus(1'b1, `USC_OFS_CTRL, 32'h0, q);
        bus(1'b0, `USC_OFS_CTRL, 32'h0, q);
        chk(line_tx_oe, 1'b0);
        node.send_frame(8'h5C, 1'b0, 1'b0);
        wait_st(`USC_ST_RXFULL, 1'b1);
        bus(1'b0, `USC_OFS_RXDATA, 32'h0, q);
        chk(q, 32'h0000_005C);
    endtask
    // Disabled block ignores a send
    task automatic t_dis();
        logic [31:0] q;
        logic        low;
        low = 1'b0;
        bus(1'b1, `USC_OFS_ENABLE, 32'h0, q);
        bus(1'b1, `USC_OFS_CTRL, 32'h0000_0001, q);
        chk(line_tx_oe, 1'b0);
        bus(1'b1, `USC_OFS_TXDATA, 32'h0000_0033, q);
        for (int i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            if (line_tx !== 1'b1) low = 1'b1;
        end
        chk(low, 1'b0);
    endtask
    // ==========================================
    // Clock, watchdog and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Whole run needs well under a tenth of this
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_fields();
        t_tx();
        t_break();
        t_rx();
        t_dis();
        wrap_up();
    end
endmodule
`default_nettype wire
